// [inc/prs_pkg.sv]
// constants, register map and state layout of the pin remap lock block
// assumes a single 250 MHz core clock and a synchronous active-high reset
//
// Functional notes
// [RULE1] locked map writes complete but change nothing
// [RULE2] lock is bit 6 of oscillator control
// [RULE3] keys 0x46 then 0x57, then lock write
// [RULE4] lock holds until next keyed change
// [RULE5] shadow copies compared; mismatch requests reset
// [RULE6] one-way config blocks clearing a set lock
// [RULE7] one-way config defaults set after reset; code sets it only during reset, then loads ONE_WAY_LOCK_CFG_IN
// [RULE8] nine input and eight output map registers
// [RULE9] select 0..25 picks pin, all ones grounds
// [RULE10] input select fields reset to all ones
// [RULE11] unimplemented map bits ignore writes, read zero
// [RULE12] irq1 select bits 12-8, irq2 bits 4-0
// [RULE13] timer3 clock 12-8, timer2 clock 4-0
// [RULE14] capture2 select 12-8, capture1 4-0
// [RULE15] capture8 select 12-8, capture7 4-0
// [RULE16] compare fault select 4-0 only
// [RULE17] output select zero keeps default port data
// [RULE18] any other write abandons the key sequence
package prs_pkg;

  localparam int NUM_IN_REGS  = 9;
  localparam int NUM_OUT_REGS = 8;
  localparam int NUM_IN_SEL   = 2 * NUM_IN_REGS;
  localparam int NUM_OUT_PINS = 2 * NUM_OUT_REGS;
  localparam int NUM_PINS     = 26;
  localparam int NUM_FUNCS    = 32;
  localparam int SEL_W        = 5;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int MAP_W        = 16;
  localparam int FIELD_HI_LSB = 8;
  localparam int FIELD_LO_LSB = 0;
  localparam int LOCK_BIT     = 6;
  localparam int CFG_ONE_WAY_BIT = 0;

  localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19;
  localparam logic [SEL_W-1:0] SEL_TIE_LOW = 5'h1F;
  localparam logic [SEL_W-1:0] SEL_NULL    = 5'h00;
  localparam logic [7:0]       KEY_FIRST   = 8'h46;
  localparam logic [7:0]       KEY_SECOND  = 8'h57;

  localparam logic [MAP_W-1:0] FIELD_HI = 16'h1F00;
  localparam logic [MAP_W-1:0] FIELD_LO = 16'h001F;
  localparam logic [MAP_W-1:0] IN_SEL_RESET  = 16'h1F1F;
  localparam logic [MAP_W-1:0] OUT_SEL_RESET = 16'h0000;
  localparam logic             ONE_WAY_RESET = 1'b1;

  // implemented fields: irq1, irq2, timers, capt 1/2, capt 7/8, fault, uart, spi, slave sel
  localparam logic [NUM_IN_REGS-1:0][MAP_W-1:0] IN_IMPL_MASK = {
    FIELD_LO, FIELD_HI | FIELD_LO, FIELD_HI | FIELD_LO, FIELD_LO,
    FIELD_HI | FIELD_LO, FIELD_HI | FIELD_LO, FIELD_HI | FIELD_LO, FIELD_LO, FIELD_HI};

  // byte addresses
  localparam logic [ADDR_W-1:0] OFS_IN_BASE    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_BASE   = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_OSC_CTRL   = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_CFG        = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h90;
  localparam logic [1:0]        REGION_IN  = 2'h0;
  localparam logic [1:0]        REGION_OUT = 2'h1;

  // interrupt events
  localparam int EV_W        = 4;
  localparam int EV_BLOCKED  = 0;
  localparam int EV_REFUSED  = 1;
  localparam int EV_ABORT    = 2;
  localparam int EV_MISMATCH = 3;

  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_HALF  = 3'b010,
    KEY_ARMED = 3'b100
  } prs_key_t;

  typedef struct packed {
    logic [NUM_IN_REGS-1:0][MAP_W-1:0]  in_map;
    logic [NUM_IN_REGS-1:0][MAP_W-1:0]  in_shadow;
    logic [NUM_OUT_REGS-1:0][MAP_W-1:0] out_map;
    logic [NUM_OUT_REGS-1:0][MAP_W-1:0] out_shadow;
    logic                               lock;
    logic                               been_locked;
    logic                               one_way;
    logic                               cfg_loaded;
    prs_key_t                           key;
    logic [EV_W-1:0]                    status;
    logic [EV_W-1:0]                    enable;
    logic                               ack;
    logic                               waitreq;
    logic [DATA_W-1:0]                  rdata;
    logic                               irq;
    logic                               mismatch_rst;
    logic [1:0][NUM_PINS-1:0]           pin_sync;
    logic [NUM_IN_SEL-1:0]              periph_in;
    logic [NUM_OUT_PINS-1:0]            pin_out;
  } prs_state_t;

endpackage

// [core/prs_remap_lock.sv]
// pin remap lock: keyed write lock, shadow monitor and pin muxes behind Avalon-MM
// assumes pins arrive asynchronously; peripheral and port data come from core-clock logic
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module prs_remap_lock
  import prs_pkg::*;
(
  // clock and reset
  input  wire logic                    CORE_CLK_IN,
  input  wire logic                    SYS_RST_IN,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]       AVM_ADDRESS_IN,
  input  wire logic                    AVM_READ_IN,
  input  wire logic                    AVM_WRITE_IN,
  input  wire logic [DATA_W-1:0]       AVM_WRITEDATA_IN,
  input  wire logic [3:0]              AVM_BYTEENABLE_IN,
  output logic      [DATA_W-1:0]       AVM_READDATA_OUT,
  output logic                         AVM_WAITREQUEST_OUT,
  // configuration fuse and pins
  input  wire logic                    ONE_WAY_LOCK_CFG_IN,
  input  wire logic [NUM_PINS-1:0]     REMAPPABLE_PIN_IN,
  input  wire logic [NUM_FUNCS-1:0]    PERIPH_OUT_IN,
  input  wire logic [NUM_OUT_PINS-1:0] PORT_DATA_IN,
  // mapped signals
  output logic      [NUM_IN_SEL-1:0]   MAPPED_INPUT_OUT,
  output logic      [NUM_OUT_PINS-1:0] REMAPPABLE_PIN_OUT,
  // status
  output logic                         MAP_WRITE_LOCK_OUT,
  output logic                         MISMATCH_RST_OUT,
  output logic                         IRQ_OUT
);

  prs_state_t s_reg;
  prs_state_t s_next;

  function automatic logic [SEL_W-1:0] sel_field(input logic [MAP_W-1:0] r, input logic hi);
    return hi ? r[FIELD_HI_LSB +: SEL_W] : r[FIELD_LO_LSB +: SEL_W];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic              req;
  logic              wr;
  logic [3:0]        idx;
  logic              in_hit;
  logic              out_hit;
  logic              osc_wr;
  logic [MAP_W-1:0]  be_mask;
  logic [MAP_W-1:0]  wr_mask;
  logic [DATA_W-1:0] rd_mux;
  logic              mism;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   clr;
  logic [SEL_W-1:0]  sel;

  assign req     = (AVM_READ_IN | AVM_WRITE_IN) & ~s_reg.ack;
  assign wr      = AVM_WRITE_IN & s_reg.ack;
  assign idx     = AVM_ADDRESS_IN[5:2];
  // [RULE8] nine input, eight output
  assign in_hit  = (AVM_ADDRESS_IN[7:6] == REGION_IN) && (idx < 4'(NUM_IN_REGS))
                   && (AVM_ADDRESS_IN[1:0] == 2'h0);
  assign out_hit = (AVM_ADDRESS_IN[7:6] == REGION_OUT) && (idx < 4'(NUM_OUT_REGS))
                   && (AVM_ADDRESS_IN[1:0] == 2'h0);
  // [RULE3] key bytes in low byte
  assign osc_wr  = wr && (AVM_ADDRESS_IN == OFS_OSC_CTRL) && AVM_BYTEENABLE_IN[0];
  assign be_mask = {{8{AVM_BYTEENABLE_IN[1]}}, {8{AVM_BYTEENABLE_IN[0]}}};

  always_comb
  begin
    rd_mux = '0;
    if (in_hit)
    begin
      // [RULE11] unimplemented bits read zero
      rd_mux[MAP_W-1:0] = s_reg.in_map[idx] & IN_IMPL_MASK[idx];
    end
    else if (out_hit)
    begin
      rd_mux[MAP_W-1:0] = s_reg.out_map[idx] & (FIELD_HI | FIELD_LO);
    end
    else
    begin
      unique case (AVM_ADDRESS_IN)
        // [RULE2] lock at bit six
        OFS_OSC_CTRL:   rd_mux[LOCK_BIT] = s_reg.lock;
        OFS_CFG:        rd_mux[CFG_ONE_WAY_BIT] = s_reg.one_way;
        OFS_IRQ_STATUS: rd_mux[EV_W-1:0] = s_reg.status;
        OFS_IRQ_ENABLE: rd_mux[EV_W-1:0] = s_reg.enable;
        default:        rd_mux = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next  = s_reg;
    ev      = '0;
    clr     = '0;
    wr_mask = '0;
    sel     = '0;
    s_next.pin_sync[0] = REMAPPABLE_PIN_IN;
    s_next.pin_sync[1] = s_reg.pin_sync[0];
    s_next.ack     = req;
    s_next.waitreq = ~req;
    if (req)
    begin
      s_next.rdata = rd_mux;
    end
    if (!s_reg.cfg_loaded)
    begin
      s_next.one_way    = ONE_WAY_LOCK_CFG_IN;
      s_next.cfg_loaded = 1'b1;
    end

    if (wr)
    begin
      unique case (s_reg.key)
        KEY_IDLE:
        begin
          if (osc_wr && AVM_WRITEDATA_IN[7:0] == KEY_FIRST)
          begin
            s_next.key = KEY_HALF;
          end
        end
        KEY_HALF:
        begin
          if (osc_wr && AVM_WRITEDATA_IN[7:0] == KEY_SECOND)
          begin
            s_next.key = KEY_ARMED;
          end
          else
          begin
            // [RULE18] stray write restarts sequence
            s_next.key      = KEY_IDLE;
            ev[EV_ABORT]    = 1'b1;
          end
        end
        KEY_ARMED:
        begin
          s_next.key = KEY_IDLE;
          if (!osc_wr)
          begin
            ev[EV_ABORT] = 1'b1;
          end
          // [RULE6] one-way refuses clear
          else if (!AVM_WRITEDATA_IN[LOCK_BIT] && s_reg.one_way && s_reg.been_locked)
          begin
            ev[EV_REFUSED] = 1'b1;
          end
          else
          begin
            // [RULE4] lock only moves here
            s_next.lock = AVM_WRITEDATA_IN[LOCK_BIT];
            if (AVM_WRITEDATA_IN[LOCK_BIT])
            begin
              s_next.been_locked = 1'b1;
            end
          end
        end
        default: s_next.key = KEY_IDLE;
      endcase

      if (in_hit || out_hit)
      begin
        // [RULE1] locked write acknowledged, ignored
        if (s_reg.lock)
        begin
          ev[EV_BLOCKED] = 1'b1;
        end
        else if (in_hit)
        begin
          // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16] field masks
          wr_mask = be_mask & IN_IMPL_MASK[idx];
          s_next.in_map[idx] = (s_reg.in_map[idx] & ~wr_mask)
                               | (AVM_WRITEDATA_IN[MAP_W-1:0] & wr_mask);
          s_next.in_shadow[idx] = s_next.in_map[idx];
        end
        else
        begin
          wr_mask = be_mask & (FIELD_HI | FIELD_LO);
          s_next.out_map[idx] = (s_reg.out_map[idx] & ~wr_mask)
                                | (AVM_WRITEDATA_IN[MAP_W-1:0] & wr_mask);
          s_next.out_shadow[idx] = s_next.out_map[idx];
        end
      end

      if (AVM_ADDRESS_IN == OFS_IRQ_CLEAR)
      begin
        clr = AVM_WRITEDATA_IN[EV_W-1:0];
      end
      if (AVM_ADDRESS_IN == OFS_IRQ_ENABLE)
      begin
        s_next.enable = AVM_WRITEDATA_IN[EV_W-1:0];
      end
    end

    // [RULE5] shadow compare every cycle
    mism = (s_reg.in_map != s_reg.in_shadow) || (s_reg.out_map != s_reg.out_shadow);
    ev[EV_MISMATCH]     = mism;
    s_next.mismatch_rst = mism;

    // set beats clear
    s_next.status = (s_reg.status & ~clr) | ev;
    s_next.irq    = |(s_next.status & s_next.enable);

    // [RULE9] pin select or ground
    for (int f = 0; f < NUM_IN_SEL; f++)
    begin
      sel = sel_field(s_reg.in_map[f / 2], 1'(f % 2));
      s_next.periph_in[f] = IN_IMPL_MASK[f / 2][(f % 2) * FIELD_HI_LSB]
                            && (sel <= SEL_MAX_PIN) && s_reg.pin_sync[1][sel];
    end
    // [RULE17] null select keeps port data
    for (int p = 0; p < NUM_OUT_PINS; p++)
    begin
      sel = sel_field(s_reg.out_map[p / 2], 1'(p % 2));
      s_next.pin_out[p] = (sel == SEL_NULL) ? PORT_DATA_IN[p] : PERIPH_OUT_IN[sel];
    end

    if (SYS_RST_IN)
    begin
      s_next = '0;
      for (int r = 0; r < NUM_IN_REGS; r++)
      begin
        // [RULE10] inputs start grounded
        s_next.in_map[r]    = IN_SEL_RESET & IN_IMPL_MASK[r];
        s_next.in_shadow[r] = IN_SEL_RESET & IN_IMPL_MASK[r];
      end
      for (int r = 0; r < NUM_OUT_REGS; r++)
      begin
        s_next.out_map[r]    = OUT_SEL_RESET;
        s_next.out_shadow[r] = OUT_SEL_RESET;
      end
      // [RULE7] one-way set by default
      s_next.one_way = ONE_WAY_RESET;
      s_next.key     = KEY_IDLE;
      s_next.waitreq = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    s_reg <= s_next;
  end

  assign AVM_READDATA_OUT    = s_reg.rdata;
  assign AVM_WAITREQUEST_OUT = s_reg.waitreq;
  assign MAPPED_INPUT_OUT    = s_reg.periph_in;
  assign REMAPPABLE_PIN_OUT  = s_reg.pin_out;
  assign MAP_WRITE_LOCK_OUT  = s_reg.lock;
  assign MISMATCH_RST_OUT    = s_reg.mismatch_rst;
  assign IRQ_OUT             = s_reg.irq;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  locked_write_hold_a: assert property ( // [RULE1]
    (wr && in_hit && s_reg.lock) |=> $stable(s_reg.in_map) && s_reg.status[EV_BLOCKED])
    else $error("locked map write changed a register");

  lock_bit_read_a: assert property ( // [RULE2]
    (req && AVM_READ_IN && AVM_ADDRESS_IN == OFS_OSC_CTRL)
      |=> AVM_READDATA_OUT[LOCK_BIT] == $past(MAP_WRITE_LOCK_OUT) && !AVM_WAITREQUEST_OUT)
    else $error("lock bit read back wrong");

  key_before_lock_a: assert property ( // [RULE3]
    $changed(MAP_WRITE_LOCK_OUT) |-> $past(s_reg.key) == KEY_ARMED)
    else $error("lock changed without key sequence");

  lock_persist_a: assert property ( // [RULE4]
    (s_reg.key != KEY_ARMED) ##1 (s_reg.key != KEY_ARMED)
      |=> MAP_WRITE_LOCK_OUT == $past(MAP_WRITE_LOCK_OUT, 2))
    else $error("lock moved outside keyed write");

  shadow_reset_a: assert property ( // [RULE5]
    (s_reg.in_map != s_reg.in_shadow || s_reg.out_map != s_reg.out_shadow)
      |=> MISMATCH_RST_OUT && s_reg.status[EV_MISMATCH])
    else $error("mismatch did not raise reset");

  shadow_quiet_a: assert property ( // [RULE5]
    (s_reg.in_map == s_reg.in_shadow && s_reg.out_map == s_reg.out_shadow)
      |=> !MISMATCH_RST_OUT)
    else $error("reset raised without mismatch");

  one_way_hold_a: assert property ( // [RULE6]
    (s_reg.one_way && s_reg.been_locked && MAP_WRITE_LOCK_OUT) |=> MAP_WRITE_LOCK_OUT)
    else $error("one-way lock was cleared");

  cfg_default_a: assert property ( // [RULE7]
    $past(SYS_RST_IN) |-> s_reg.one_way && !MAP_WRITE_LOCK_OUT)
    else $error("one-way default not set after reset");

  unimpl_zero_a: assert property ( // [RULE11]
    (s_reg.in_map & ~IN_IMPL_MASK) == '0)
    else $error("unimplemented map bit set");

  ground_select_a: assert property ( // [RULE9]
    (sel_field(s_reg.in_map[1], 1'b0) == SEL_TIE_LOW) |=> !MAPPED_INPUT_OUT[2])
    else $error("grounded input not low");

  null_output_a: assert property ( // [RULE17]
    (sel_field(s_reg.out_map[0], 1'b0) == SEL_NULL) |=> REMAPPABLE_PIN_OUT[0] == $past(PORT_DATA_IN[0]))
    else $error("null select not port data");

  seq_abort_a: assert property ( // [RULE18]
    (s_reg.key == KEY_HALF && wr && !osc_wr) |=> s_reg.key == KEY_IDLE && s_reg.status[EV_ABORT])
    else $error("stray write kept key sequence");

  armed_abort_a: assert property ( // [RULE18]
    (s_reg.key == KEY_ARMED && wr && !osc_wr)
      |=> s_reg.key == KEY_IDLE && $stable(MAP_WRITE_LOCK_OUT) && s_reg.status[EV_ABORT])
    else $error("stray write after keys moved the lock");

  lock_set_a: assert property ( // [RULE3]
    (wr && osc_wr && s_reg.key == KEY_ARMED && AVM_WRITEDATA_IN[LOCK_BIT])
      |=> MAP_WRITE_LOCK_OUT)
    else $error("keyed lock write did not set lock");

  refuse_flag_a: assert property ( // [RULE6]
    (wr && osc_wr && s_reg.key == KEY_ARMED && !AVM_WRITEDATA_IN[LOCK_BIT]
      && s_reg.one_way && s_reg.been_locked)
      |=> s_reg.status[EV_REFUSED] && MAP_WRITE_LOCK_OUT)
    else $error("refused unlock not flagged");

  locked_out_hold_a: assert property ( // [RULE1]
    (wr && out_hit && s_reg.lock) |=> $stable(s_reg.out_map) && s_reg.status[EV_BLOCKED])
    else $error("locked output map write changed a register");

  reset_ground_a: assert property ( // [RULE10]
    $past(SYS_RST_IN) |-> MAPPED_INPUT_OUT == '0 && s_reg.key == KEY_IDLE
      && s_reg.in_map[0] == (IN_SEL_RESET & IN_IMPL_MASK[0]))
    else $error("input selects not grounded after reset");

  pin_route_a: assert property ( // [RULE9]
    (sel_field(s_reg.in_map[3], 1'b0) == '0)
      |=> MAPPED_INPUT_OUT[6] == $past(s_reg.pin_sync[1][0]))
    else $error("selected pin not routed to input");

  out_unused_zero_a: assert property (
    (s_reg.out_map & ~{NUM_OUT_REGS{FIELD_HI | FIELD_LO}}) == '0)
    else $error("unused output map bit set");

  wait_pulse_a: assert property (
    !AVM_WAITREQUEST_OUT |=> AVM_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");

  req_answer_a: assert property (
    req |=> !AVM_WAITREQUEST_OUT)
    else $error("request not answered next cycle");

  rdata_hold_a: assert property (
    !req |=> $stable(AVM_READDATA_OUT))
    else $error("read data moved without a request");

  unmapped_read_a: assert property (
    (req && AVM_READ_IN && AVM_ADDRESS_IN > OFS_IRQ_ENABLE) |=> AVM_READDATA_OUT == '0)
    else $error("unmapped address read nonzero");

  irq_level_a: assert property (
    IRQ_OUT == |(s_reg.status & s_reg.enable))
    else $error("interrupt does not follow enabled status");

  unlock_seen_c: cover property ($fell(MAP_WRITE_LOCK_OUT));
  refuse_seen_c: cover property (s_reg.status[EV_REFUSED]);
  map_write_c:   cover property (wr && in_hit && !s_reg.lock);
  irq_seen_c:    cover property ($rose(IRQ_OUT));
  abort_seen_c:  cover property (s_reg.status[EV_ABORT]);

endmodule // prs_remap_lock

`default_nettype wire

// [tb/prs_remap_lock_tb.sv]
// self-checking bench for the pin remap lock block
// assumes prs_pkg is compiled first; the bench itself is the avalon-mm master
`timescale 1ns/10ps
`default_nettype none

module tb
  import prs_pkg::*;
;
  typedef struct {
    logic [7:0]          a;
    logic [15:0]         wd;
    logic [15:0]         rd;
    logic [NUM_PINS-1:0] pins;
    int                  mbit;
    logic                mexp;
  } prs_row_t;

  logic                    core_clk;
  logic                    sys_rst;
  logic [ADDR_W-1:0]       av_addr;
  logic                    av_rd;
  logic                    av_wr;
  logic [DATA_W-1:0]       av_wdata;
  logic [3:0]              av_be;
  logic [DATA_W-1:0]       av_rdata;
  logic                    av_wait;
  logic                    one_way_cfg;
  logic [NUM_PINS-1:0]     pins;
  logic [NUM_FUNCS-1:0]    periph_out;
  logic [NUM_OUT_PINS-1:0] port_data;
  logic [NUM_IN_SEL-1:0]   mapped_in;
  logic [NUM_OUT_PINS-1:0] pin_out;
  logic                    map_lock;
  logic                    mismatch;
  logic                    irq;
  logic [DATA_W-1:0]       rd;
  int                      fail_count;
  int                      check_count;

  prs_row_t rows [11] = '{
    '{8'h00, 16'hFFFF, 16'h1F00, 26'h3FFFFFF, 1, 1'b0},
    '{8'h00, 16'h0300, 16'h0300, 26'h0000008, 1, 1'b1},
    '{8'h00, 16'h0300, 16'h0300, 26'h3FFFFF7, 1, 1'b0},
    '{8'h04, 16'h0019, 16'h0019, 26'h2000000, 2, 1'b1},
    '{8'h08, 16'h0A0B, 16'h0A0B, 26'h0000400, 5, 1'b1},
    '{8'h08, 16'h0A0B, 16'h0A0B, 26'h0000800, 4, 1'b1},
    '{8'h0C, 16'h0100, 16'h0100, 26'h0000001, 6, 1'b1},
    '{8'h0C, 16'h0100, 16'h0100, 26'h0000002, 7, 1'b1},
    '{8'h10, 16'h1807, 16'h1807, 26'h1000000, 9, 1'b1},
    '{8'h14, 16'hFFE4, 16'h0004, 26'h0000010, 10, 1'b1},
    '{8'h20, 16'h1A1A, 16'h001A, 26'h3FFFFFF, 16, 1'b0}};

  prs_remap_lock prs_remap_lock_inst (
    .CORE_CLK_IN         (core_clk),
    .SYS_RST_IN          (sys_rst),
    .AVM_ADDRESS_IN      (av_addr),
    .AVM_READ_IN         (av_rd),
    .AVM_WRITE_IN        (av_wr),
    .AVM_WRITEDATA_IN    (av_wdata),
    .AVM_BYTEENABLE_IN   (av_be),
    .AVM_READDATA_OUT    (av_rdata),
    .AVM_WAITREQUEST_OUT (av_wait),
    .ONE_WAY_LOCK_CFG_IN (one_way_cfg),
    .REMAPPABLE_PIN_IN   (pins),
    .PERIPH_OUT_IN       (periph_out),
    .PORT_DATA_IN        (port_data),
    .MAPPED_INPUT_OUT    (mapped_in),
    .REMAPPABLE_PIN_OUT  (pin_out),
    .MAP_WRITE_LOCK_OUT  (map_lock),
    .MISMATCH_RST_OUT    (mismatch),
    .IRQ_OUT             (irq)
  );

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access; waitrequest and read data are taken at the completing rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    av_addr <= a;
    av_wdata <= {16'h0000, d};
    av_wr <= wr;
    av_rd <= !wr;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (av_wait !== 1'b0 && n < 64);
    if (av_wait !== 1'b0)
    begin
      check(av_wait, 32'h0);
      final_report();
    end
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 16'h0000);
    check(rd & m, exp);
  endtask

  task automatic key(input logic [15:0] v);
    wr(OFS_OSC_CTRL, 16'h0046);
    wr(OFS_OSC_CTRL, 16'h0057);
    wr(OFS_OSC_CTRL, v);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (15) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    av_addr = '0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = '0;
    av_be = 4'h3;
    one_way_cfg = 1'b0;
    pins = '1;
    periph_out = '0;
    port_data = '0;
    fail_count = 0;
    check_count = 0;
    do_reset();
    check(mapped_in, 32'h0);
    for (int r = 0; r < NUM_IN_REGS; r++)
    begin
      rdchk(OFS_IN_BASE + 8'(4 * r), {16'h0, IN_SEL_RESET & IN_IMPL_MASK[r]}, 32'hFFFF);
    end
    for (int k = 0; k < NUM_OUT_REGS; k++)
    begin
      rdchk(OFS_OUT_BASE + 8'(4 * k), 32'h0, 32'hFFFF);
    end
    rdchk(OFS_OSC_CTRL, 32'h0, 32'h40);
    rdchk(OFS_CFG, 32'h0, 32'h1);
    $display("test reset done");
    foreach (rows[i])
    begin
      prs_row_t w;
      w = rows[i];
      @(posedge core_clk);
      pins <= w.pins;
      wr(w.a, w.wd);
      rdchk(w.a, {16'h0, w.rd}, '1);
      settle(6);
      check(mapped_in[w.mbit], {31'h0, w.mexp});
    end
    $display("test input map done");
    @(posedge core_clk);
    port_data <= 16'h0001;
    periph_out <= 32'h0000_0008;
    wr(8'h40, 16'h0300);
    settle(4);
    check(pin_out[1:0], 32'h3);
    @(posedge core_clk);
    port_data <= 16'h0000;
    periph_out <= 32'hFFFF_FFF7;
    settle(3);
    check(pin_out, 32'h0);
    $display("test output map done");
    key(16'h0040);
    settle(2);
    check(map_lock, 32'h1);
    rdchk(OFS_OSC_CTRL, 32'h40, 32'h40);
    wr(OFS_IRQ_CLEAR, 16'h000F);
    wr(OFS_IRQ_ENABLE, 16'h0001);
    wr(8'h0C, 16'h0505);
    rdchk(8'h0C, 32'h0100, 32'hFFFF);
    wr(8'h5C, 16'h001F);
    rdchk(8'h5C, 32'h0, 32'hFFFF);
    rdchk(OFS_IRQ_STATUS, 32'h1, 32'h1);
    settle(2);
    check(irq, 32'h1);
    wr(OFS_IRQ_CLEAR, 16'h0001);
    settle(2);
    check(irq, 32'h0);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    wr(8'h0C, 16'h0505);
    settle(2);
    check(irq, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h1, 32'h1);
    $display("test lock done");
    key(16'h0000);
    wr(8'h0C, 16'h0505);
    wr(8'h14, 16'h0007);
    rdchk(8'h0C, 32'h0505, 32'hFFFF);
    rdchk(8'h14, 32'h0007, 32'hFFFF);
    check(map_lock, 32'h0);
    // upper byte lane only: low field keeps its value
    @(posedge core_clk);
    av_be <= 4'h2;
    wr(8'h0C, 16'h1313);
    @(posedge core_clk);
    av_be <= 4'h3;
    rdchk(8'h0C, 32'h1305, 32'hFFFF);
    wr(OFS_IRQ_CLEAR, 16'h000F);
    wr(OFS_OSC_CTRL, 16'h0046);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    wr(OFS_OSC_CTRL, 16'h0057);
    wr(OFS_OSC_CTRL, 16'h0040);
    settle(2);
    check(map_lock, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h4, 32'h4);
    // stray write after both keys
    wr(OFS_IRQ_CLEAR, 16'h000F);
    wr(OFS_OSC_CTRL, 16'h0046);
    wr(OFS_OSC_CTRL, 16'h0057);
    wr(OFS_IRQ_ENABLE, 16'h0000);
    wr(OFS_OSC_CTRL, 16'h0040);
    settle(2);
    check(map_lock, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h4, 32'h4);
    wr(8'hF0, 16'hFFFF);
    rdchk(8'hF0, 32'h0, 32'hFFFF_FFFF);
    check(mismatch, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h0, 32'h8);
    $display("test unlock done");
    @(posedge core_clk);
    one_way_cfg <= 1'b1;
    do_reset();
    rdchk(OFS_CFG, 32'h1, 32'h1);
    rdchk(8'h0C, 32'h1F1F, 32'hFFFF);
    key(16'h0040);
    key(16'h0000);
    settle(2);
    check(map_lock, 32'h1);
    rdchk(OFS_IRQ_STATUS, 32'h2, 32'h2);
    wr(8'h0C, 16'h0101);
    rdchk(8'h0C, 32'h1F1F, 32'hFFFF);
    $display("test one way done");
    final_report();
  end

endmodule // tb

`default_nettype wire
